// ===== src/axis_select_and_status_display.sv
// module: power-on axis selection and front-panel status sequencing
// ======================================================================
// Overview of operation
// - capture switch once at power-up only
// - values 0-6 give axes 1-7; 7-E unusable
// - value F: axis unused, never controlled
// - unused axis holds fixed code on display
// - both powers on: diagnose then initialise automatically
// - display steps through progress indications
// - alarm replaces progress with alarm number
`timescale 1ns/1ps
`default_nettype none
module axis_select_and_status_display
#(
    parameter int DIAG_LEN = axis_sel_pkg::DIAG_CYCLES,
    parameter int INIT_LEN = axis_sel_pkg::INIT_CYCLES
)
(
    // clock and reset (srst models amplifier power-on)
    input wire logic clk,
    input wire logic srst,
    // operator and system inputs
    input wire logic [axis_sel_pkg::SW_W-1:0] rotary_sw,
    input wire logic ctrl_pwr_on,
    input wire logic alarm_act,
    input wire logic [axis_sel_pkg::ALARM_W-1:0] alarm_num,
    // status outputs
    output logic [axis_sel_pkg::AXIS_W-1:0] axis_idx_r,
    output logic axis_valid_r,
    output logic axis_unused_r,
    output logic cfg_err_r,
    output logic control_en_r,
    output logic ready_r,
    output logic [axis_sel_pkg::LED_W-1:0] led_code_r
);
    import axis_sel_pkg::*;

    // ==================================================================
    // sequencer
    state_t state_r;
    state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [SW_W-1:0] sw_cap_r;
    logic [LED_W-1:0] code_nxt;
    localparam logic [CNT_W-1:0] DIAG_LAST = CNT_W'(DIAG_LEN - 1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_LEN - 1);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_CAPTURE:
            begin
                if (sw_cap_r == SW_UNUSED)
                    state_nxt = ST_UNUSED;
                else if (sw_cap_r > SW_AXIS_LAST)
                    state_nxt = ST_CFG_ERR;
                else
                    state_nxt = ST_WAIT_PWR;
            end
            ST_WAIT_PWR: if (ctrl_pwr_on) state_nxt = ST_DIAG;
            ST_DIAG: if (cnt_r == DIAG_LAST) state_nxt = ST_INIT;
            ST_INIT: if (cnt_r == INIT_LAST) state_nxt = ST_READY;
            ST_READY, ST_UNUSED, ST_CFG_ERR: state_nxt = state_r;
            default: state_nxt = ST_CAPTURE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_r <= ST_CAPTURE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk)
    begin
        if (srst || state_nxt != state_r)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 1'b1;
    end

    // ==================================================================
    // switch capture: sampled while in power-up reset, then frozen
    always_ff @(posedge clk)
    begin
        if (srst)
            sw_cap_r <= rotary_sw;
    end

    // ==================================================================
    // decoded configuration
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            axis_idx_r <= '0;
            axis_valid_r <= 1'b0;
            axis_unused_r <= 1'b0;
            cfg_err_r <= 1'b0;
        end
        else if (state_r == ST_CAPTURE)
        begin
            // an unusable or unused setting adopts no axis number
            axis_idx_r <= (sw_cap_r <= SW_AXIS_LAST) ? sw_cap_r[AXIS_W-1:0] : '0;
            axis_valid_r <= sw_cap_r <= SW_AXIS_LAST;
            axis_unused_r <= sw_cap_r == SW_UNUSED;
            cfg_err_r <= sw_cap_r > SW_AXIS_LAST && sw_cap_r != SW_UNUSED;
        end
    end

    // ==================================================================
    // control enables
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            control_en_r <= 1'b0;
            ready_r <= 1'b0;
        end
        else
        begin
            control_en_r <= state_nxt == ST_READY && !alarm_act;
            ready_r <= state_nxt == ST_READY;
        end
    end

    // ==================================================================
    // display
    led_code_mux u_led
    (
        .state(state_nxt),
        .axis_idx(sw_cap_r[AXIS_W-1:0]),
        .alarm_act(alarm_act),
        .alarm_num(alarm_num),
        .code(code_nxt)
    );

    always_ff @(posedge clk)
    begin
        if (srst)
            led_code_r <= LED_BLANK;
        else
            led_code_r <= code_nxt;
    end

    // ==================================================================
    // checks
    logic past_valid_r;
    always_ff @(posedge clk)
    begin
        if (srst)
            past_valid_r <= 1'b0;
        else
            past_valid_r <= 1'b1;
    end

    property p_sw_frozen;
        @(posedge clk) disable iff (srst) past_valid_r |-> $stable(sw_cap_r);
    endproperty
    a_sw_frozen: assert property (p_sw_frozen)
        else $error("captured switch changed after power-up");

    property p_axis_decode;
        @(posedge clk) disable iff (srst)
            (state_r == ST_WAIT_PWR) |-> axis_valid_r && axis_idx_r == sw_cap_r[AXIS_W-1:0];
    endproperty
    a_axis_decode: assert property (p_axis_decode)
        else $error("axis decode mismatch");

    property p_unused_no_ctrl;
        @(posedge clk) disable iff (srst) axis_unused_r |-> !control_en_r && !ready_r;
    endproperty
    a_unused_no_ctrl: assert property (p_unused_no_ctrl)
        else $error("unused axis is controlled");

    property p_unused_code;
        @(posedge clk) disable iff (srst)
            (state_r == ST_UNUSED) |=> led_code_r == unused_axis_display_code;
    endproperty
    a_unused_code: assert property (p_unused_code)
        else $error("unused code not shown");

    property p_diag_start;
        @(posedge clk) disable iff (srst)
            (state_r == ST_WAIT_PWR && ctrl_pwr_on)
            |=> (state_r == ST_DIAG) ##1 (led_code_r == LED_DIAG || $past(alarm_act));
    endproperty
    a_diag_start: assert property (p_diag_start)
        else $error("diagnosis did not start");

    property p_progress;
        @(posedge clk) disable iff (srst)
            $rose(state_r == ST_INIT) |-> $past(state_r) == ST_DIAG;
    endproperty
    a_progress: assert property (p_progress)
        else $error("initialisation without diagnosis");

    property p_alarm_show;
        @(posedge clk) disable iff (srst)
            (alarm_act && (state_nxt == ST_DIAG || state_nxt == ST_INIT || state_nxt == ST_READY))
            |=> led_code_r == $past(alarm_num);
    endproperty
    a_alarm_show: assert property (p_alarm_show)
        else $error("alarm number not shown");

    property p_cfg_err;
        @(posedge clk) disable iff (srst)
            cfg_err_r |-> !axis_valid_r && !control_en_r && axis_idx_r == '0;
    endproperty
    a_cfg_err: assert property (p_cfg_err)
        else $error("unusable setting adopted");

    c_ready: cover property (@(posedge clk) disable iff (srst) $rose(ready_r));
    c_unused: cover property (@(posedge clk) disable iff (srst) $rose(axis_unused_r));
    c_cfg_err: cover property (@(posedge clk) disable iff (srst) $rose(cfg_err_r));
    c_alarm: cover property (@(posedge clk) disable iff (srst) ready_r && alarm_act);
endmodule : axis_select_and_status_display
`default_nettype wire

// ===== src/axis_sel_pkg.sv
// package: constants and types for axis selection and status display
package axis_sel_pkg;
    localparam int SW_W = 4;
    localparam int LED_W = 8;
    localparam int AXIS_W = 3;
    localparam int ALARM_W = 8;
    localparam logic [SW_W-1:0] SW_AXIS_LAST = 4'h6;
    localparam logic [SW_W-1:0] SW_UNUSED = 4'hF;
    // led codes shown on the two-digit display
    localparam logic [LED_W-1:0] unused_axis_display_code = 8'hAB;
    localparam logic [LED_W-1:0] LED_BLANK = 8'h00;
    localparam logic [LED_W-1:0] LED_CFG_ERR = 8'hEE;
    localparam logic [LED_W-1:0] LED_DIAG = 8'hAA;
    localparam logic [LED_W-1:0] LED_INIT = 8'hAC;
    localparam logic [LED_W-1:0] LED_READY_BASE = 8'hD0;
    // phase lengths in ns, cycles at 200 MHz
    localparam int CLK_PERIOD_NS = 5;
    localparam int DIAG_TIME_NS = 1000;
    localparam int INIT_TIME_NS = 1000;
    localparam int DIAG_CYCLES = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_CYCLES = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    typedef enum logic [2:0]
    {
        ST_CAPTURE = 3'b000,
        ST_WAIT_PWR = 3'b001,
        ST_DIAG = 3'b011,
        ST_INIT = 3'b010,
        ST_READY = 3'b110,
        ST_UNUSED = 3'b111,
        ST_CFG_ERR = 3'b101
    } state_t;
endpackage : axis_sel_pkg

// ===== src/led_code_mux.sv
// module: selects the code shown on the front-panel display
`timescale 1ns/1ps
`default_nettype none
module led_code_mux
(
    // inputs
    input wire axis_sel_pkg::state_t state,
    input wire logic [axis_sel_pkg::AXIS_W-1:0] axis_idx,
    input wire logic alarm_act,
    input wire logic [axis_sel_pkg::ALARM_W-1:0] alarm_num,
    // output
    output logic [axis_sel_pkg::LED_W-1:0] code
);
    import axis_sel_pkg::*;
    always_comb
    begin
        case (state)
            ST_UNUSED: code = unused_axis_display_code;
            ST_CFG_ERR: code = LED_CFG_ERR;
            ST_CAPTURE, ST_WAIT_PWR: code = LED_BLANK;
            default:
            begin
                if (alarm_act)
                    code = alarm_num;
                else if (state == ST_DIAG)
                    code = LED_DIAG;
                else if (state == ST_INIT)
                    code = LED_INIT;
                else
                    code = LED_READY_BASE | {{(LED_W-AXIS_W){1'b0}}, axis_idx};
            end
        endcase
    end
endmodule : led_code_mux
`default_nettype wire

// ===== dv/panel_model.sv
// operator switch and controller power source facing the block
`timescale 1ns/1ps
`default_nettype none
module panel_model
(
    // towards the block
    output logic [axis_sel_pkg::SW_W-1:0] rotary_sw,
    output logic ctrl_pwr_on
);
    import axis_sel_pkg::*;
    initial
    begin
        rotary_sw = 4'h0;
        ctrl_pwr_on = 1'b0;
    end
    // operator sets position while unit is held in power-up, and again after release to check the freeze
    task automatic set_sw(input logic [SW_W-1:0] v);
        rotary_sw = v;
    endtask : set_sw
    // controller power switched on or off by the test, also while the unit runs
    task automatic set_pwr(input logic v);
        ctrl_pwr_on = v;
    endtask : set_pwr
endmodule : panel_model
`default_nettype wire

// ===== dv/axis_select_and_status_display_tb_top.sv
// testbench for axis selection and status display
`timescale 1ns/1ps
`default_nettype none
module axis_select_and_status_display_tb_top;
    import axis_sel_pkg::*;
    localparam int LEN = 4;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic alarm_act = 1'b0;
    logic [ALARM_W-1:0] alarm_num = 8'h00;
    logic [SW_W-1:0] rotary_sw;
    logic ctrl_pwr_on;
    logic [AXIS_W-1:0] axis_idx_r;
    logic axis_valid_r, axis_unused_r, cfg_err_r, control_en_r, ready_r;
    logic [LED_W-1:0] led_code_r;
    int fail_count = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    panel_model u_panel_model (.rotary_sw(rotary_sw), .ctrl_pwr_on(ctrl_pwr_on));
    axis_select_and_status_display #(.DIAG_LEN(LEN), .INIT_LEN(LEN))
    u_axis_select_and_status_display
    (
        .clk(clk), .srst(srst), .rotary_sw(rotary_sw), .ctrl_pwr_on(ctrl_pwr_on),
        .alarm_act(alarm_act), .alarm_num(alarm_num), .axis_idx_r(axis_idx_r),
        .axis_valid_r(axis_valid_r), .axis_unused_r(axis_unused_r), .cfg_err_r(cfg_err_r),
        .control_en_r(control_en_r), .ready_r(ready_r), .led_code_r(led_code_r)
    );
    // ======================================================================
    // helpers
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic chk_code(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_code
    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit
    task automatic wait_led(input logic [7:0] code);
        int i;
        for (i = 0; i < 60 && led_code_r !== code; i++)
            @(negedge clk);
        chk_code("led_code_r", code, led_code_r);
        if (led_code_r !== code)
            report_and_stop();
    endtask : wait_led
    task automatic power_up(input logic [3:0] sw, input logic pwr);
        @(negedge clk);
        srst = 1'b1;
        u_panel_model.set_sw(sw);
        u_panel_model.set_pwr(pwr);
        repeat (5) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        u_panel_model.set_sw(~sw);
    endtask : power_up
    task automatic chk_flags(input logic [4:0] exp);
        chk_bit("axis_valid_r", exp[4], axis_valid_r);
        chk_bit("axis_unused_r", exp[3], axis_unused_r);
        chk_bit("cfg_err_r", exp[2], cfg_err_r);
        chk_bit("ready_r", exp[1], ready_r);
        chk_bit("control_en_r", exp[0], control_en_r);
    endtask : chk_flags
    // ======================================================================
    // scenarios
    task automatic t_axes();
        for (int v = 0; v < 7; v++)
        begin
            power_up(4'(v), 1'b1);
            wait_led(LED_DIAG);
            wait_led(LED_INIT);
            wait_led(LED_READY_BASE | 8'(v));
            chk_code("axis_idx_r", 8'(v), {5'h00, axis_idx_r});
            chk_flags(5'b10011);
        end
    endtask : t_axes
    task automatic t_bad();
        alarm_num = 8'h55;
        for (int v = 7; v < 16; v++)
        begin
            alarm_act = (v > 12);
            power_up(4'(v), 1'b1);
            repeat (LEN * 4) @(negedge clk);
            chk_code("led_code_r", (v == 15) ? unused_axis_display_code : LED_CFG_ERR,
                     led_code_r);
            chk_flags((v == 15) ? 5'b01000 : 5'b00100);
            chk_code("axis_idx_r", 8'h00, {5'h00, axis_idx_r});
        end
        alarm_act = 1'b0;
    endtask : t_bad
    task automatic t_nopwr();
        power_up(4'h2, 1'b0);
        repeat (LEN * 4) @(negedge clk);
        chk_flags(5'b10000);
        u_panel_model.set_pwr(1'b1);
        wait_led(LED_DIAG);
        // controller power drop after start is ignored
        u_panel_model.set_pwr(1'b0);
        wait_led(8'hD2);
        u_panel_model.set_pwr(1'b1);
        chk_flags(5'b10011);
    endtask : t_nopwr
    task automatic t_alarm();
        alarm_num = 8'h42;
        alarm_act = 1'b1;
        @(negedge clk);
        chk_code("led_code_r", 8'h42, led_code_r);
        chk_bit("control_en_r", 1'b0, control_en_r);
        alarm_num = 8'h17;
        @(negedge clk);
        chk_code("led_code_r", 8'h17, led_code_r);
        alarm_act = 1'b0;
        @(negedge clk);
        chk_code("led_code_r", 8'hD2, led_code_r);
        chk_bit("control_en_r", 1'b1, control_en_r);
    endtask : t_alarm
    initial
    begin
        t_axes();
        t_bad();
        t_nopwr();
        t_alarm();
        report_and_stop();
    end
endmodule : axis_select_and_status_display_tb_top
`default_nettype wire
